// file: src/sct_timer.sv
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - counter advances at cpu clock over 2, 4, 8 or external clock
// - write to either counter low byte reloads counter with FFFCh
// - reset loads FFFCh, the only reload value in every mode
// - alternate counter view reads same value, never clears rollover flag
// - high byte read freezes low byte in a buffer until low is read
// - lone low byte read after complete sequence returns live low byte
// - rollover FFFFh to 0000h sets rollover flag in every mode
// - rollover irq asserted while flag, enable set and cpu mask clear
// - rollover flag clears by status read then counter low access
// - counter runs in wait, frozen in halt, resumes held count
// - clock select field both ones selects external clock pin
// - edge select bit chooses rising or falling external edge
// - external clock is synchronised before it advances the counter
// - capture words latch counter on active pin edge, newest wins
// - capture edge one in control one, edge two in control two
// - capture sets channel flag; one enable gates irq with cpu mask
// - capture flag clears by status read then capture low access
// - capture high read blocks channel captures until low is read
// - in single pulse or pwm mode only channel two captures
// - capture pin two always feeds capture logic, pin one not in single pulse or pwm mode; only the selected edge counts
// - capture flag appears two to three clocks after the pin event
module sct_timer
    import sct_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic cpu_irq_mask,
    input wire logic halt_mode,
    input wire logic ext_clock_pin,
    input wire logic capture_pin_one,
    input wire logic capture_pin_two,
    output logic rollover_irq,
    output logic capture_irq
);

    // ========================================================
    // pin synchronisers
    // ========================================================
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] pin_prev;
    logic [2:0] next_sync_a;
    logic [2:0] next_sync_b;

    always_comb begin
        next_sync_a = {capture_pin_two, capture_pin_one, ext_clock_pin};
        next_sync_b = sync_a;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            pin_prev <= 3'h0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            pin_prev <= sync_b;
        end
    end

    function automatic logic edge_hit(input logic now, input logic was,
                                      input logic rising);
        edge_hit = rising ? (now & ~was) : (~now & was);
    endfunction : edge_hit

    // ========================================================
    // registers and counter
    // ========================================================
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [15:0] count_word;
    logic [2:0] presc;
    logic [7:0] low_buf;
    logic low_frozen;
    logic roll_flag;
    logic roll_armed;
    logic [1:0] cap_flag;
    logic [1:0] cap_armed;
    logic [1:0] cap_block;
    logic [15:0] cap_word [2];
    logic [7:0] next_ctrl_one;
    logic [7:0] next_ctrl_two;
    logic [15:0] next_count_word;
    logic [2:0] next_presc;
    logic [7:0] next_low_buf;
    logic next_low_frozen;
    logic next_roll_flag;
    logic next_roll_armed;
    logic [1:0] next_cap_flag;
    logic [1:0] next_cap_armed;
    logic [1:0] next_cap_block;
    logic [15:0] next_cap_word [2];
    logic tick;
    logic [1:0] cap_event;
    logic [1:0] cap_edge_sel;
    logic pulse_modes;
    logic wr_cnt_lo;
    logic acc_cnt_lo;
    logic rd_status;

    always_comb begin
        logic [1:0] clk_sel;
        clk_sel = ctrl_two[CR2_CLK_SEL_LO +: 2];
        case (clk_sel)
            CLK_DIV2: tick = presc[0];
            CLK_DIV4: tick = &presc[1:0];
            CLK_DIV8: tick = &presc;
            CLK_EXT: tick = edge_hit(sync_b[0], pin_prev[0],
                                     ctrl_two[CR2_EXT_EDGE]);
            default: tick = 1'b0;
        endcase
        // halt also holds the prescaler, so a wake-up resumes the same phase
        if (halt_mode) begin
            tick = 1'b0;
        end
    end

    always_comb begin
        cap_edge_sel = {ctrl_two[CR2_CAP_EDGE_TWO],
                        ctrl_one[CR1_CAP_EDGE_ONE]};
        pulse_modes = ctrl_two[CR2_SINGLE_PULSE] | ctrl_two[CR2_PWM_MODE];
        for (int i = 0; i < 2; i++) begin
            cap_event[i] = edge_hit(sync_b[i+1], pin_prev[i+1],
                                    cap_edge_sel[i]);
        end
        if (pulse_modes) begin
            cap_event[0] = 1'b0;
        end
        wr_cnt_lo = reg_write &&
                    (reg_addr == ADDR_CNT_LO || reg_addr == ADDR_ALT_LO);
        acc_cnt_lo = (reg_write || reg_read) && reg_addr == ADDR_CNT_LO;
        rd_status = reg_read && reg_addr == ADDR_STATUS;
    end

    always_comb begin
        next_ctrl_one = ctrl_one;
        next_ctrl_two = ctrl_two;
        next_presc = halt_mode ? presc : presc + 3'd1;
        next_count_word = tick ? count_word + 16'd1 : count_word;
        next_low_buf = low_buf;
        next_low_frozen = low_frozen;
        next_roll_flag = roll_flag;
        next_roll_armed = roll_armed;
        next_cap_flag = cap_flag;
        next_cap_armed = cap_armed;
        next_cap_block = cap_block;
        next_cap_word = cap_word;
        if (reg_write && reg_addr == ADDR_CTRL_ONE) begin
            next_ctrl_one = reg_wdata;
        end
        if (reg_write && reg_addr == ADDR_CTRL_TWO) begin
            next_ctrl_two = reg_wdata;
        end
        if (wr_cnt_lo) begin
            next_count_word = COUNT_RELOAD;
            next_presc = PRESC_RESET;
        end
        if (reg_read && (reg_addr == ADDR_CNT_HI ||
                         reg_addr == ADDR_ALT_HI) && !low_frozen) begin
            next_low_buf = count_word[7:0];
            next_low_frozen = 1'b1;
        end
        if (reg_read && (reg_addr == ADDR_CNT_LO ||
                         reg_addr == ADDR_ALT_LO)) begin
            next_low_frozen = 1'b0;
        end
        // clear steps first so that a same-cycle set wins
        if (rd_status && roll_flag) begin
            next_roll_armed = 1'b1;
        end
        if (acc_cnt_lo && roll_armed) begin
            next_roll_flag = 1'b0;
            next_roll_armed = 1'b0;
        end
        if (tick && count_word == 16'hFFFF) begin
            next_roll_flag = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            logic [3:0] lo_a;
            logic [3:0] hi_a;
            lo_a = (i == 0) ? ADDR_CAP1_LO : ADDR_CAP2_LO;
            hi_a = (i == 0) ? ADDR_CAP1_HI : ADDR_CAP2_HI;
            if (rd_status && cap_flag[i]) begin
                next_cap_armed[i] = 1'b1;
            end
            if ((reg_read || reg_write) && reg_addr == lo_a) begin
                if (cap_armed[i]) begin
                    next_cap_flag[i] = 1'b0;
                    next_cap_armed[i] = 1'b0;
                end
            end
            if (reg_read && reg_addr == lo_a) begin
                next_cap_block[i] = 1'b0;
            end
            if (reg_read && reg_addr == hi_a) begin
                next_cap_block[i] = 1'b1;
            end
            if (cap_event[i] && !cap_block[i]) begin
                next_cap_word[i] = count_word;
                next_cap_flag[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_one <= CTRL_RESET;
            ctrl_two <= CTRL_RESET;
            count_word <= COUNT_RELOAD;
            presc <= PRESC_RESET;
            low_buf <= 8'h00;
            low_frozen <= 1'b0;
            roll_flag <= 1'b0;
            roll_armed <= 1'b0;
            cap_flag <= 2'b00;
            cap_armed <= 2'b00;
            cap_block <= 2'b00;
            cap_word[0] <= 16'h0000;
            cap_word[1] <= 16'h0000;
        end else begin
            ctrl_one <= next_ctrl_one;
            ctrl_two <= next_ctrl_two;
            count_word <= next_count_word;
            presc <= next_presc;
            low_buf <= next_low_buf;
            low_frozen <= next_low_frozen;
            roll_flag <= next_roll_flag;
            roll_armed <= next_roll_armed;
            cap_flag <= next_cap_flag;
            cap_armed <= next_cap_armed;
            cap_block <= next_cap_block;
            cap_word <= next_cap_word;
        end
    end

    // ========================================================
    // read port and interrupt requests
    // ========================================================
    logic [7:0] next_rdata;
    logic [7:0] status_byte;

    always_comb begin
        status_byte = 8'h00;
        status_byte[SR_CAP_FLAG_ONE] = cap_flag[0];
        status_byte[SR_CAP_FLAG_TWO] = cap_flag[1];
        status_byte[SR_ROLL_FLAG] = roll_flag;
        next_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                ADDR_CTRL_ONE: next_rdata = ctrl_one;
                ADDR_CTRL_TWO: next_rdata = ctrl_two;
                ADDR_STATUS: next_rdata = status_byte;
                ADDR_CAP1_HI: next_rdata = cap_word[0][15:8];
                ADDR_CAP1_LO: next_rdata = cap_word[0][7:0];
                ADDR_CAP2_HI: next_rdata = cap_word[1][15:8];
                ADDR_CAP2_LO: next_rdata = cap_word[1][7:0];
                ADDR_CNT_HI,
                ADDR_ALT_HI: next_rdata = count_word[15:8];
                ADDR_CNT_LO,
                ADDR_ALT_LO: next_rdata = low_frozen ? low_buf
                                          : count_word[7:0];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // pending flags simply wait for enable and mask to allow them
    assign rollover_irq = roll_flag & ctrl_one[CR1_ROLL_IRQ_EN]
                          & ~cpu_irq_mask;
    assign capture_irq = (|cap_flag) & ctrl_one[CR1_CAP_IRQ_EN]
                         & ~cpu_irq_mask;

    // ========================================================
    // checks
    // ========================================================
    default clocking chk_clk @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // the arm step and the touch step of the rollover clear
    sequence roll_arm_s;
        rd_status && roll_flag;
    endsequence
    sequence roll_touch_s;
        acc_cnt_lo && roll_armed && !(tick && count_word == 16'hFFFF);
    endsequence
    // a qualifying edge on the raw pin, before the two sync stages
    sequence cap_seen_one_s;
        (cap_edge_sel[0] ? $rose(capture_pin_one) : $fell(capture_pin_one))
        && !cap_block[0] && !pulse_modes;
    endsequence
    sequence cap_seen_two_s;
        (cap_edge_sel[1] ? $rose(capture_pin_two) : $fell(capture_pin_two))
        && !cap_block[1];
    endsequence

    reload_on_write_a: assert property (
        wr_cnt_lo |=> count_word == COUNT_RELOAD)
        else $error("counter not reloaded");
    roll_set_a: assert property (
        tick && count_word == 16'hFFFF && !wr_cnt_lo
        |=> roll_flag && count_word == 16'h0000)
        else $error("rollover flag missing");
    roll_clear_a: assert property (
        $fell(roll_flag) |-> $past(acc_cnt_lo) && $past(roll_armed))
        else $error("rollover flag cleared early");
    roll_clear_seq_a: assert property (
        roll_arm_s ##[1:20] roll_touch_s |=> !roll_flag)
        else $error("rollover flag kept after clear sequence");
    roll_irq_a: assert property (
        rollover_irq |-> roll_flag && !cpu_irq_mask)
        else $error("rollover irq without cause");
    alt_keep_a: assert property (
        reg_read && reg_addr == ADDR_ALT_LO && roll_flag |=> roll_flag)
        else $error("alternate low read cleared rollover flag");
    halt_freeze_a: assert property (
        halt_mode && !wr_cnt_lo |=> $stable(count_word))
        else $error("counter moved in halt");
    buffer_load_a: assert property (
        reg_read && reg_addr == ADDR_CNT_HI && !low_frozen
        |=> low_frozen && low_buf == $past(count_word[7:0]))
        else $error("low byte not buffered");
    live_low_a: assert property (
        reg_read && reg_addr == ADDR_ALT_LO && !low_frozen
        |=> reg_rdata == $past(count_word[7:0]))
        else $error("lone low read not live");
    cap_block_a: assert property (
        cap_block[1] |=> $stable(cap_word[1]))
        else $error("capture two while blocked");
    cap_block_one_a: assert property (
        cap_block[0] |=> $stable(cap_word[0]))
        else $error("capture one while blocked");
    cap_flag_a: assert property (
        cap_event[1] && !cap_block[1] |=> cap_flag[1]
        && cap_word[1] == $past(count_word))
        else $error("capture not taken");
    cap_delay_one_a: assert property (
        cap_seen_one_s |-> ##[2:3] cap_flag[0])
        else $error("capture flag one late");
    cap_delay_two_a: assert property (
        cap_seen_two_s |-> ##[2:3] cap_flag[1])
        else $error("capture flag two late");
    cap_clear_a: assert property (
        $fell(cap_flag[0]) |-> $past(cap_armed[0]))
        else $error("capture flag one cleared early");
    cap_irq_a: assert property (
        capture_irq |-> (|cap_flag) && !cpu_irq_mask)
        else $error("capture irq without cause");
    pulse_cap_a: assert property (
        pulse_modes && !cap_flag[0] |=> !cap_flag[0])
        else $error("channel one captured in pulse mode");
    frozen_low_a: assert property (
        low_frozen ##1 low_frozen |-> $stable(low_buf))
        else $error("low buffer moved");

endmodule : sct_timer

// file: include/sct_pkg.sv
package sct_pkg;
    // register map: byte-wide registers on a plain port
    localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
    localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_CAP1_HI = 4'h4;
    localparam logic [3:0] ADDR_CAP1_LO = 4'h5;
    localparam logic [3:0] ADDR_CNT_HI = 4'h8;
    localparam logic [3:0] ADDR_CNT_LO = 4'h9;
    localparam logic [3:0] ADDR_ALT_HI = 4'hA;
    localparam logic [3:0] ADDR_ALT_LO = 4'hB;
    localparam logic [3:0] ADDR_CAP2_HI = 4'hC;
    localparam logic [3:0] ADDR_CAP2_LO = 4'hD;
    // control_register_one fields
    localparam int CR1_CAP_IRQ_EN = 7;
    localparam int CR1_CAP_EDGE_ONE = 1;
    localparam int CR1_ROLL_IRQ_EN = 5;
    // control_register_two fields
    localparam int CR2_SINGLE_PULSE = 4;
    // kept clear of the clock select field at bits 3:2
    localparam int CR2_PWM_MODE = 5;
    localparam int CR2_CLK_SEL_LO = 2;
    localparam int CR2_EXT_EDGE = 0;
    localparam int CR2_CAP_EDGE_TWO = 1;
    // timer_status_register fields
    localparam int SR_CAP_FLAG_ONE = 7;
    localparam int SR_CAP_FLAG_TWO = 4;
    localparam int SR_ROLL_FLAG = 5;
    // clock select codes
    localparam logic [1:0] CLK_DIV4 = 2'b00;
    localparam logic [1:0] CLK_DIV2 = 2'b01;
    localparam logic [1:0] CLK_DIV8 = 2'b10;
    localparam logic [1:0] CLK_EXT = 2'b11;
    // reset and reload values
    localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] PRESC_RESET = 3'h0;
endpackage : sct_pkg

// file: bench/sct_pins_model.sv
`timescale 1ns/100ps
// ==========
// far side: external clock source and capture pin drivers
module sct_pins_model (
    input wire logic ref_clk,
    output logic ext_clock_pin,
    output logic capture_pin_one,
    output logic capture_pin_two
);
    initial begin
        ext_clock_pin = 1'b0;
        capture_pin_one = 1'b0;
        capture_pin_two = 1'b0;
    end
    // active edges seven clocks apart, clear of the four clock minimum
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            ext_clock_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            ext_clock_pin <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask : ext_pulses
    task automatic cap_pulse(input int ch);
        @(posedge ref_clk);
        if (ch == 1) capture_pin_one <= 1'b1;
        else capture_pin_two <= 1'b1;
        repeat (4) @(posedge ref_clk);
        capture_pin_one <= 1'b0;
        capture_pin_two <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : cap_pulse
endmodule : sct_pins_model

// file: bench/sct_timer_tb.sv
`timescale 1ns/100ps
module sct_timer_tb;
    import sct_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic cpu_irq_mask = 1'b1;
    logic halt_mode = 1'b1;
    logic [7:0] reg_rdata;
    logic ext_clock_pin;
    logic capture_pin_one;
    logic capture_pin_two;
    logic rollover_irq;
    logic capture_irq;
    int err_count = 0;
    int compares = 0;
    logic [7:0] v;
    logic [15:0] cnt;
    logic [15:0] d;
    int e;
    logic [1:0] codes [3] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8};
    int divs [3] = '{2, 4, 8};
    always #5 ref_clk = ~ref_clk;
    sct_timer dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .cpu_irq_mask(cpu_irq_mask),
        .halt_mode(halt_mode), .ext_clock_pin(ext_clock_pin),
        .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
        .rollover_irq(rollover_irq), .capture_irq(capture_irq));
    sct_pins_model pins (.ref_clk(ref_clk), .ext_clock_pin(ext_clock_pin),
        .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two));
    // ==========
    // access tasks
    task automatic check(input string n, input logic [7:0] x,
                         input logic [7:0] g);
        compares++;
        if (g !== x) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] w);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic rd16(input logic [3:0] a);
        rd(a);
        cnt[15:8] = v;
        rd(4'(a + 4'h1));
        cnt[7:0] = v;
    endtask : rd16
    // halt also freezes the prescaler, so counts between runs stay exact
    task automatic run(input int n);
        @(posedge ref_clk);
        halt_mode <= 1'b0;
        repeat (n) @(posedge ref_clk);
        halt_mode <= 1'b1;
    endtask : run
    task automatic conclude();
        $display("compares %0d, err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        conclude();
    end
    // ==========
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        rd(ADDR_CTRL_ONE);
        check("ctrl one", CTRL_RESET, v);
        rd(ADDR_CTRL_TWO);
        check("ctrl two", CTRL_RESET, v);
        rd(ADDR_STATUS);
        check("status", 8'h00, v);
        rd16(ADDR_CNT_HI);
        check("count hi", 8'hFF, cnt[15:8]);
        check("count lo", 8'hFC, cnt[7:0]);
        wr(4'h3, 8'h5A);
        rd(4'h3);
        check("unmapped", 8'h00, v);
        rd(ADDR_CNT_HI);
        run(40);
        rd(ADDR_CNT_HI);
        check("count hi again", 8'h00, v);
        rd(ADDR_CNT_LO);
        check("buffered lo", 8'hFC, v);
        rd(ADDR_STATUS);
        check("rollover", 8'h01, 8'(v[SR_ROLL_FLAG]));
        wr(ADDR_CTRL_ONE, 8'h20);
        #1 check("irq masked", 8'h00, 8'(rollover_irq));
        cpu_irq_mask <= 1'b0;
        @(posedge ref_clk);
        #1 check("irq", 8'h01, 8'(rollover_irq));
        rd(ADDR_ALT_LO);
        check("live lo", 8'h01, 8'(v !== 8'hFC));
        rd(ADDR_STATUS);
        check("alt no clear", 8'h01, 8'(v[SR_ROLL_FLAG]));
        rd(ADDR_CNT_LO);
        rd(ADDR_STATUS);
        check("rollover clr", 8'h00, 8'(v[SR_ROLL_FLAG]));
        check("irq clr", 8'h00, 8'(rollover_irq));
        wr(ADDR_CNT_LO, 8'h00);
        rd16(ADDR_CNT_HI);
        check("reload hi", 8'hFF, cnt[15:8]);
        check("reload lo", 8'hFC, cnt[7:0]);
        run(20);
        wr(ADDR_ALT_LO, 8'h00);
        rd16(ADDR_ALT_HI);
        check("alt reload hi", 8'hFF, cnt[15:8]);
        check("alt reload lo", 8'hFC, cnt[7:0]);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL_TWO, {4'h0, codes[i], 2'b00});
            wr(ADDR_CNT_LO, 8'h00);
            run(96);
            rd16(ADDR_CNT_HI);
            d = cnt + 16'h0004;
            e = int'(d) - 96 / divs[i];
            check("rate", 8'h01, 8'(e >= -1 && e <= 1));
        end
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL_TWO, {4'h0, CLK_EXT, 1'b0, 1'(i)});
            wr(ADDR_CNT_LO, 8'h00);
            @(posedge ref_clk);
            halt_mode <= 1'b0;
            pins.ext_pulses(5 + i);
            repeat (8) @(posedge ref_clk);
            halt_mode <= 1'b1;
            rd16(ADDR_CNT_HI);
            d = cnt + 16'h0004;
            check("ext count", 8'(5 + i), d[7:0]);
        end
        wr(ADDR_CTRL_TWO, 8'h02);
        wr(ADDR_CTRL_ONE, 8'h82);
        wr(ADDR_CNT_LO, 8'h00);
        pins.cap_pulse(1);
        rd(ADDR_STATUS);
        check("cap flag", 8'h01, 8'(v[SR_CAP_FLAG_ONE]));
        check("cap irq", 8'h01, 8'(capture_irq));
        rd16(ADDR_CAP1_HI);
        check("cap word hi", 8'hFF, cnt[15:8]);
        check("cap word lo", 8'hFC, cnt[7:0]);
        rd(ADDR_STATUS);
        check("cap clr", 8'h00, 8'(v[SR_CAP_FLAG_ONE]));
        check("cap irq clr", 8'h00, 8'(capture_irq));
        rd(ADDR_CAP1_HI);
        run(40);
        pins.cap_pulse(1);
        rd(ADDR_STATUS);
        check("blocked flag", 8'h00, 8'(v[SR_CAP_FLAG_ONE]));
        rd(ADDR_CAP1_LO);
        check("blocked word", 8'hFC, v);
        pins.cap_pulse(1);
        rd16(ADDR_CAP1_HI);
        check("newest word", 8'h00, cnt[15:8]);
        rd(ADDR_STATUS);
        rd(ADDR_CAP1_LO);
        wr(ADDR_CTRL_TWO, 8'h12);
        pins.cap_pulse(1);
        rd(ADDR_STATUS);
        check("one in pulse", 8'h00, 8'(v[SR_CAP_FLAG_ONE]));
        pins.cap_pulse(2);
        rd(ADDR_STATUS);
        check("two in pulse", 8'h01, 8'(v[SR_CAP_FLAG_TWO]));
        rd(ADDR_CAP2_LO);
        rd(ADDR_CAP2_HI);
        wr(ADDR_CTRL_TWO, 8'h20);
        pins.cap_pulse(1);
        pins.cap_pulse(2);
        rd(ADDR_STATUS);
        check("one in pwm", 8'h00, 8'(v[SR_CAP_FLAG_ONE]));
        check("two blocked", 8'h00, 8'(v[SR_CAP_FLAG_TWO]));
        rd(ADDR_CAP2_LO);
        pins.cap_pulse(2);
        rd(ADDR_STATUS);
        check("two falling", 8'h01, 8'(v[SR_CAP_FLAG_TWO]));
        conclude();
    end
endmodule : sct_timer_tb
